// *** verilog/sar_adc_control_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_consts.svh"
module sar_adc_control_sequencer
  import sar_adc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // system and trigger inputs
  input wire logic idle_mode_i,
  input wire logic rc_osc_i,
  input wire logic ext_trig_pin_i,
  input wire logic pwm_interval_i,
  input wire logic timer_compare_i,
  // analog front end
  input wire logic comparator_i,
  output logic converter_enable_o,
  output logic [3:0] sample_o,
  output logic [1:0] conv_channel_o,
  output logic [11:0] dac_code_o,
  output logic [4:0] ch0_input_o,
  output logic input_set_b_o,
  output logic ref_pos_ext_o,
  output logic ref_neg_ext_o,
  // results towards buffer and dma
  output logic [15:0] result_o,
  output logic [11:0] result_addr_o,
  output logic result_valid_o,
  output logic group_done_o,
  output logic dma_req_o
);
  seq_regs_type s_q;
  seq_regs_type s_d;
  logic run;
  logic conv_tick;
  logic sar_start;
  logic sar_abort;
  logic sar_busy;
  logic sar_done;
  logic [11:0] sar_code;
  logic trig;
  logic sw_start;
  logic sw_stop;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [1:0] last_ch;
  logic [4:0] index;
  logic [11:0] sg_addr;
  logic [11:0] seq_addr;

  function automatic logic [15:0] fmt_result(input logic [11:0] raw, input logic res12,
                                             input logic [1:0] sel);
    logic [15:0] v;
    v = 16'h0000;
    if (res12) begin
      unique case (sel)
        2'h0: v = {4'h0, raw};
        2'h1: v = {{5{~raw[11]}}, raw[10:0]};
        2'h2: v = {raw, 4'h0};
        2'h3: v = {~raw[11], raw[10:0], 4'h0};
      endcase
    end else begin
      unique case (sel)
        2'h0: v = {6'h00, raw[9:0]};
        2'h1: v = {{7{~raw[9]}}, raw[8:0]};
        2'h2: v = {raw[9:0], 6'h00};
        2'h3: v = {~raw[9], raw[8:0], 6'h00};
      endcase
    end
    return v;
  endfunction

  // with wrap clear, lowest selected input above cur, else lowest selected overall
  function automatic logic [4:0] next_scan(input logic [31:0] list, input logic [4:0] cur,
                                           input logic wrap);
    logic [4:0] low;
    logic [4:0] above;
    logic found;
    low = 5'h00;
    above = 5'h00;
    found = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (list[i]) begin
        low = 5'(i);
        if (5'(i) > cur) begin
          above = 5'(i);
          found = 1'b1;
        end
      end
    end
    return (found && !wrap) ? above : low;
  endfunction

  function automatic logic [31:0] read_word(input seq_regs_type r, input logic [7:0] a);
    logic [31:0] w;
    w = `WORD_RESET;
    unique case (a)
      `OFS_CTL1: begin
        w[`CTL1_ON] = r.on;
        w[`CTL1_IDLE_STOP] = r.idle_stop;
        w[`CTL1_DMA_ORDER] = r.dma_order;
        w[`CTL1_RES12] = r.res12;
        w[`CTL1_FMT +: 2] = r.fmt_sel;
        w[`CTL1_TRIG +: 3] = r.trig_src;
        w[`CTL1_SIM] = r.sim_sampling_active & ~r.res12;
        w[`CTL1_AUTO] = r.auto_start;
        w[`CTL1_SAMPLING] = (r.state == st_sample);
        w[`CTL1_DONE] = r.done;
      end
      `OFS_CTL2: begin
        w[`CTL2_REF +: 3] = r.ref_cfg;
        w[`CTL2_SCAN] = r.scan_en;
        w[`CTL2_CHCNT +: 2] = r.res12 ? 2'h0 : r.ch_count;
        w[`CTL2_HALF] = r.split_buf & r.half;
        w[`CTL2_OPS +: 4] = r.ops_per_inc;
        w[`CTL2_SPLIT] = r.split_buf;
        w[`CTL2_ALT] = r.alt_input;
      end
      `OFS_CTL3: begin
        w[`CTL3_RC] = r.rc_src;
        w[`CTL3_STIME +: 5] = r.sample_time;
        w[`CTL3_DIV +: 6] = r.clk_div;
      end
      `OFS_CTL4: w[`CTL4_DMALEN +: 3] = r.dma_len;
      `OFS_INSEL: begin
        w[`INSEL_A +: 5] = r.sel_a;
        w[`INSEL_B +: 5] = r.sel_b;
      end
      `OFS_SCAN: w = r.scan_list;
      `OFS_RESULT: w[15:0] = r.result;
      default: w = `WORD_RESET;
    endcase
    return w;
  endfunction

  conv_tick_gen u_tick (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .enable_i(run && !sar_start), // restart so the first trial settles through the comparator sync
    .rc_src_i(s_q.rc_src),
    .clk_div_i(s_q.clk_div),
    .rc_tick_i(s_q.rc_s2 & ~s_q.rc_prev),
    .tick_o(conv_tick)
  );

  sar_engine u_sar (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .start_i(sar_start),
    .abort_i(sar_abort),
    .tick_i(conv_tick),
    .res12_i(s_q.res12),
    .comp_i(s_q.comp_s2),
    .busy_o(sar_busy),
    .done_o(sar_done),
    .code_o(sar_code)
  );

  always_comb begin
    hit = (paddr_i == `OFS_CTL1) || (paddr_i == `OFS_CTL2) || (paddr_i == `OFS_CTL3) ||
          (paddr_i == `OFS_CTL4) || (paddr_i == `OFS_INSEL) || (paddr_i == `OFS_SCAN) ||
          (paddr_i == `OFS_RESULT);
    wr_en = psel_i && penable_i && pwrite_i;
    rd_en = psel_i && !penable_i && !pwrite_i;
    // an idle request only halts the block when idle_stop is set
    run = s_q.on && !(s_q.idle_stop && idle_mode_i);
    last_ch = s_q.res12 ? 2'h0 : (s_q.ch_count == 2'h0) ? 2'h0 :
              (s_q.ch_count == 2'h1) ? 2'h1 : 2'h3;
    index = (s_q.ch == 2'h0) ? s_q.cur_in : 5'(s_q.ch - 2'h1);
    sg_addr = (12'(index) << s_q.dma_len) + 12'(s_q.sg_cnt & 7'((8'h01 << s_q.dma_len) - 8'h01));
    seq_addr = s_q.split_buf ? {8'h00, s_q.half, s_q.wr_ptr[2:0]} : {8'h00, s_q.wr_ptr};
    sw_start = 1'b0;
    sw_stop = 1'b0;
    sar_start = 1'b0;
    sar_abort = !run;
    trig = 1'b0;

    s_d = s_q;
    s_d.result_valid = 1'b0;
    s_d.event_p = 1'b0;
    s_d.pin_s1 = ext_trig_pin_i;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_prev = s_q.pin_s2;
    s_d.rc_s1 = rc_osc_i;
    s_d.rc_s2 = s_q.rc_s1;
    s_d.rc_prev = s_q.rc_s2;
    s_d.comp_s1 = comparator_i;
    s_d.comp_s2 = s_q.comp_s1;
    if (rd_en) begin
      s_d.prdata = read_word(s_q, paddr_i);
    end

    if (wr_en) begin
      unique case (paddr_i)
        `OFS_CTL1: begin
          s_d.on = pwdata_i[`CTL1_ON];
          s_d.idle_stop = pwdata_i[`CTL1_IDLE_STOP];
          s_d.dma_order = pwdata_i[`CTL1_DMA_ORDER];
          s_d.res12 = pwdata_i[`CTL1_RES12];
          s_d.fmt_sel = pwdata_i[`CTL1_FMT +: 2];
          s_d.trig_src = pwdata_i[`CTL1_TRIG +: 3];
          s_d.sim_sampling_active = pwdata_i[`CTL1_SIM];
          s_d.auto_start = pwdata_i[`CTL1_AUTO];
          sw_start = pwdata_i[`CTL1_SAMPLING] && !s_q.auto_start;
          sw_stop = !pwdata_i[`CTL1_SAMPLING] && (s_q.trig_src == `TRIG_SW);
          if (!pwdata_i[`CTL1_DONE]) begin
            s_d.done = 1'b0; // a one is ignored
          end
        end
        `OFS_CTL2: begin
          s_d.ref_cfg = pwdata_i[`CTL2_REF +: 3];
          s_d.scan_en = pwdata_i[`CTL2_SCAN];
          s_d.ch_count = pwdata_i[`CTL2_CHCNT +: 2];
          s_d.ops_per_inc = pwdata_i[`CTL2_OPS +: 4];
          s_d.split_buf = pwdata_i[`CTL2_SPLIT];
          s_d.alt_input = pwdata_i[`CTL2_ALT];
        end
        `OFS_CTL3: begin
          s_d.rc_src = pwdata_i[`CTL3_RC];
          s_d.sample_time = pwdata_i[`CTL3_STIME +: 5];
          s_d.clk_div = pwdata_i[`CTL3_DIV +: 6];
        end
        `OFS_CTL4: s_d.dma_len = pwdata_i[`CTL4_DMALEN +: 3];
        `OFS_INSEL: begin
          s_d.sel_a = pwdata_i[`INSEL_A +: 5];
          s_d.sel_b = pwdata_i[`INSEL_B +: 5];
        end
        `OFS_SCAN: s_d.scan_list = pwdata_i;
        default: ;
      endcase
    end

    unique case (s_q.trig_src)
      `TRIG_SW: trig = sw_stop;
      `TRIG_PIN: trig = s_q.pin_s2 && !s_q.pin_prev;
      `TRIG_TIMER: trig = timer_compare_i;
      `TRIG_PWM: trig = pwm_interval_i;
      `TRIG_AUTO: trig = (s_q.tick_cnt == s_q.sample_time);
      default: trig = 1'b0;
    endcase

    unique case (s_q.state)
      st_hold: begin
        if (run && (s_q.auto_start || sw_start)) begin
          s_d.state = st_sample;
          s_d.tick_cnt = 5'h00;
          if (s_q.use_b) begin
            s_d.cur_in = s_q.sel_b;
          end else if (s_q.scan_en) begin
            s_d.cur_in = s_q.scan_ptr;
          end else begin
            s_d.cur_in = s_q.sel_a;
          end
        end
      end
      st_sample: begin
        if (!run) begin
          s_d.state = st_hold;
        end else if (trig) begin
          // hardware ends sampling itself for the pin, timer, pwm and internal counter sources; reserved codes 4 to 6 never end it
          s_d.state = st_convert;
          s_d.ch = 2'h0;
          s_d.done = 1'b0;
          sar_start = 1'b1;
        end else if (conv_tick && (s_q.tick_cnt != s_q.sample_time)) begin
          s_d.tick_cnt = s_q.tick_cnt + 5'h01;
        end
      end
      st_convert: begin
        if (!run) begin
          s_d.state = st_hold;
        end else if (sar_done) begin
          s_d.result = fmt_result(sar_code, s_q.res12, s_q.fmt_sel);
          s_d.result_addr = s_q.dma_order ? seq_addr : sg_addr;
          s_d.result_valid = 1'b1;
          s_d.wr_ptr = s_q.wr_ptr + 4'h1;
          if (s_q.ch != last_ch) begin
            s_d.ch = s_q.ch + 2'h1;
            sar_start = 1'b1;
          end else begin
            s_d.state = st_hold;
            s_d.done = 1'b1; // set after any clear above
            s_d.use_b = s_q.alt_input && !s_q.use_b;
            if (s_q.scan_en && !s_q.use_b) begin
              s_d.scan_ptr = next_scan(s_q.scan_list, s_q.scan_ptr, 1'b0);
            end
            if (s_q.ops >= s_q.ops_per_inc) begin
              s_d.ops = 4'h0;
              s_d.event_p = 1'b1;
              s_d.wr_ptr = 4'h0;
              s_d.half = s_q.split_buf && !s_q.half;
              s_d.sg_cnt = s_q.sg_cnt + 7'h01;
              s_d.scan_ptr = next_scan(s_q.scan_list, s_q.scan_ptr, 1'b1);
            end else begin
              s_d.ops = s_q.ops + 4'h1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // sequential mode lets each later channel keep tracking until its turn
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      sample_o[i] = (2'(i) <= last_ch) &&
                    ((s_q.state == st_sample) ||
                     (s_q.state == st_convert && !s_q.sim_sampling_active && 2'(i) > s_q.ch));
    end
  end

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit;
  assign prdata_o = s_q.prdata;
  assign converter_enable_o = run;
  assign conv_channel_o = s_q.ch;
  assign dac_code_o = sar_code;
  assign ch0_input_o = s_q.cur_in;
  assign input_set_b_o = s_q.use_b;
  assign ref_pos_ext_o = (s_q.ref_cfg == 3'h1) || (s_q.ref_cfg == 3'h3);
  assign ref_neg_ext_o = (s_q.ref_cfg == 3'h2) || (s_q.ref_cfg == 3'h3);
  assign result_o = s_q.result;
  assign result_addr_o = s_q.result_addr;
  assign result_valid_o = s_q.result_valid;
  assign group_done_o = s_q.event_p;
  assign dma_req_o = s_q.event_p;
endmodule // sar_adc_control_sequencer
`default_nettype wire

// *** verilog/sar_adc_consts.svh ***
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH
// register byte offsets
`define OFS_CTL1 8'h00
`define OFS_CTL2 8'h04
`define OFS_CTL3 8'h08
`define OFS_CTL4 8'h0C
`define OFS_INSEL 8'h10
`define OFS_SCAN 8'h14
`define OFS_RESULT 8'h18
// reset values
`define CTL_RESET 16'h0000
`define WORD_RESET 32'h0000_0000
// converter_control_one field positions
`define CTL1_ON 15
`define CTL1_IDLE_STOP 13
`define CTL1_DMA_ORDER 12
`define CTL1_RES12 10
`define CTL1_FMT 8
`define CTL1_TRIG 5
`define CTL1_SIM 3
`define CTL1_AUTO 2
`define CTL1_SAMPLING 1
`define CTL1_DONE 0
// converter_control_two field positions
`define CTL2_REF 13
`define CTL2_SCAN 10
`define CTL2_CHCNT 8
`define CTL2_HALF 7
`define CTL2_OPS 2
`define CTL2_SPLIT 1
`define CTL2_ALT 0
// converter_control_three field positions
`define CTL3_RC 15
`define CTL3_STIME 8
`define CTL3_DIV 0
// converter_control_four and input select field positions
`define CTL4_DMALEN 0
`define INSEL_A 0
`define INSEL_B 8
// trigger source codes
`define TRIG_SW 3'h0
`define TRIG_PIN 3'h1
`define TRIG_TIMER 3'h2
`define TRIG_PWM 3'h3
`define TRIG_AUTO 3'h7
// upper buffer half
`define HALF_BASE 4'h8
`endif

// *** verilog/sar_adc_pkg.sv ***
package sar_adc_pkg;
  typedef enum logic [1:0] {st_hold, st_sample, st_convert} seq_state_type;

  typedef struct packed {
    logic on;
    logic idle_stop;
    logic dma_order;
    logic res12;
    logic [1:0] fmt_sel;
    logic [2:0] trig_src;
    logic sim_sampling_active;
    logic auto_start;
    logic done;
    logic [2:0] ref_cfg;
    logic scan_en;
    logic [1:0] ch_count;
    logic [3:0] ops_per_inc;
    logic split_buf;
    logic alt_input;
    logic rc_src;
    logic [4:0] sample_time;
    logic [5:0] clk_div;
    logic [2:0] dma_len;
    logic [4:0] sel_a;
    logic [4:0] sel_b;
    logic [31:0] scan_list;
    seq_state_type state;
    logic [4:0] tick_cnt;
    logic [1:0] ch;
    logic use_b;
    logic [4:0] scan_ptr;
    logic [4:0] cur_in;
    logic [3:0] ops;
    logic [3:0] wr_ptr;
    logic half;
    logic [6:0] sg_cnt;
    logic [15:0] result;
    logic [11:0] result_addr;
    logic result_valid;
    logic event_p;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic rc_s1;
    logic rc_s2;
    logic rc_prev;
    logic comp_s1;
    logic comp_s2;
    logic [31:0] prdata;
  } seq_regs_type;

  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } div_regs_type;

  typedef struct packed {
    logic busy;
    logic done;
    logic [3:0] bit_idx;
    logic [11:0] code;
  } sar_regs_type;
endpackage

// *** verilog/conv_tick_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module conv_tick_gen
  import sar_adc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic enable_i,
  input wire logic rc_src_i,
  input wire logic [5:0] clk_div_i,
  input wire logic rc_tick_i,
  // tick out
  output logic tick_o
);
  div_regs_type s_q;
  div_regs_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!enable_i) begin
      s_d.cnt = 6'h00;
    end else if (rc_src_i) begin
      s_d.tick = rc_tick_i;
    end else if (s_q.cnt == clk_div_i) begin
      s_d.cnt = 6'h00; // period is divider plus one cycles
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;
endmodule // conv_tick_gen
`default_nettype wire

// *** verilog/sar_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
module sar_engine
  import sar_adc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic tick_i,
  input wire logic res12_i,
  input wire logic comp_i,
  // status and data
  output logic busy_o,
  output logic done_o,
  output logic [11:0] code_o
);
  sar_regs_type s_q;
  sar_regs_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (abort_i) begin
      s_d.busy = 1'b0;
    end else if (start_i) begin
      s_d.busy = 1'b1;
      s_d.bit_idx = res12_i ? 4'hB : 4'h9;
      s_d.code = 12'h000;
      s_d.code[s_d.bit_idx] = 1'b1;
    end else if (s_q.busy && tick_i) begin
      // comparator high keeps the trial bit
      if (!comp_i) begin
        s_d.code[s_q.bit_idx] = 1'b0;
      end
      if (s_q.bit_idx == 4'h0) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.bit_idx = s_q.bit_idx - 4'h1;
        s_d.code[s_d.bit_idx] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_o = s_q.busy;
  assign done_o = s_q.done;
  assign code_o = s_q.code;
endmodule // sar_engine
`default_nettype wire

// *** tb/sar_adc_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_consts.svh"
module sar_adc_props
  import sar_adc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  // front end and results
  input wire logic idle_mode_i,
  input wire logic converter_enable_o,
  input wire logic [3:0] sample_o,
  input wire logic ref_pos_ext_o,
  input wire logic ref_neg_ext_o,
  input wire logic [15:0] result_o,
  input wire logic result_valid_o,
  input wire logic group_done_o,
  input wire logic dma_req_o
);
  // shadows of the software-written control words
  logic [15:0] c1_q;
  logic [15:0] c2_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      c1_q <= 16'h0000;
      c2_q <= 16'h0000;
    end else if (psel_i && penable_i && pwrite_i) begin
      if (paddr_i == `OFS_CTL1) c1_q <= pwdata_i[15:0];
      if (paddr_i == `OFS_CTL2) c2_q <= pwdata_i[15:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_unmapped_err: assert property (
    psel_i && penable_i && paddr_i > `OFS_RESULT |-> pslverr_o) else $error("unmapped access not refused");
  a_unmapped_zero: assert property (
    psel_i && penable_i && !pwrite_i && paddr_i > `OFS_RESULT |-> prdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_enable_decode: assert property (
    converter_enable_o == (c1_q[15] && !(c1_q[13] && idle_mode_i))) else $error("enable mismatch");
  a_ref_pos: assert property (
    ref_pos_ext_o == (c2_q[15:13] == 3'h1 || c2_q[15:13] == 3'h3)) else $error("positive ref wrong");
  a_ref_neg: assert property (
    ref_neg_ext_o == (c2_q[15:13] == 3'h2 || c2_q[15:13] == 3'h3)) else $error("negative ref wrong");
  a_off_quiet: assert property (
    !converter_enable_o [*3] |-> !result_valid_o && sample_o == 4'h0) else $error("activity while off");
  a_dma_pairs: assert property (
    dma_req_o == group_done_o && (!dma_req_o || result_valid_o)) else $error("dma request not at group end");
  a_valid_spacing: assert property (
    result_valid_o |=> !result_valid_o [*2]) else $error("results too close");
  a_int_format: assert property (
    result_valid_o && c1_q[10:8] == 3'h0 |-> result_o[15:10] == 6'h00) else $error("integer upper bits set");
  a_frac_format: assert property (
    result_valid_o && c1_q[9:8] == 2'h2 |-> result_o[3:0] == 4'h0) else $error("fraction low bits set");
  c_group: cover property (group_done_o);
  c_refused: cover property (pslverr_o);
  c_wide: cover property (result_valid_o && c1_q[10]);
endmodule // sar_adc_props
`default_nettype wire

// *** tb/adc_front_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_front_model
  import sar_adc_pkg::*;
(
  // trial code and held level
  input wire logic [11:0] dac_code_i,
  input wire logic [11:0] level_i,
  // comparator decision
  output logic comp_o
);
  // ideal comparator; no offset, so results are exact
  assign comp_o = (level_i >= dac_code_i);
endmodule // adc_front_model
`default_nettype wire

// *** tb/sar_adc_control_sequencer_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_consts.svh"
module sar_adc_control_sequencer_tb_top
  import sar_adc_pkg::*;
;
  logic clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
  logic idle_mode_i, rc_osc_i, ext_trig_pin_i, pwm_interval_i, timer_compare_i, comparator_i;
  logic converter_enable_o, result_valid_o, group_done_o, dma_req_o, ref_pos_ext_o, ref_neg_ext_o;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [3:0] sample_o;
  logic [11:0] dac_code_o, result_addr_o, level;
  logic [15:0] result_o, c1;
  int n_errors = 0, checked = 0, k, nv, ns;
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  sar_adc_control_sequencer uut (
    .clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .idle_mode_i, .rc_osc_i, .ext_trig_pin_i, .pwm_interval_i, .timer_compare_i,
    .comparator_i, .converter_enable_o, .sample_o, .conv_channel_o(), .dac_code_o, .ch0_input_o(),
    .input_set_b_o(), .ref_pos_ext_o, .ref_neg_ext_o, .result_o, .result_addr_o, .result_valid_o,
    .group_done_o, .dma_req_o);
  adc_front_model front (.dac_code_i(dac_code_o), .level_i(level), .comp_o(comparator_i));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // waits for a result, or a group end, counting results and sampling cycles
  task automatic watch(input logic grp, input int lim);
    k = 0;
    nv = 0;
    ns = 0;
    do begin
      @(posedge clk_i);
      k++;
      nv += (result_valid_o === 1'b1);
      ns += (sample_o[0] === 1'b1);
    end while ((grp ? group_done_o : result_valid_o) !== 1'b1 && k < lim);
  endtask
  function automatic logic [15:0] fmt_exp(input logic r, input logic [1:0] f, input logic [11:0] c);
    logic s;
    s = r ? ~c[11] : ~c[9];
    case ({r, f})
      3'h0: fmt_exp = {6'h00, c[9:0]};
      3'h1: fmt_exp = {{7{s}}, c[8:0]};
      3'h2: fmt_exp = {c[9:0], 6'h00};
      3'h3: fmt_exp = {s, c[8:0], 6'h00};
      3'h4: fmt_exp = {4'h0, c};
      3'h5: fmt_exp = {{5{s}}, c[10:0]};
      3'h6: fmt_exp = {c, 4'h0};
      default: fmt_exp = {s, c[10:0], 4'h0};
    endcase
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    wrap_up;
  end
  initial begin
    rst_b_i = 1'b0;
    {psel_i, penable_i, pwrite_i, idle_mode_i, rc_osc_i} = 5'h00;
    {ext_trig_pin_i, pwm_interval_i, timer_compare_i} = 3'h0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0000_0000;
    level = 12'h000;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b1, `OFS_CTL3, 32'hFFFF_FFFF);
    apb(1'b0, `OFS_CTL3, 32'h0);
    chk("control three bits", 32'h0000_9F3F, rd);
    apb(1'b1, `OFS_CTL2, 32'hFFFF_FFFF);
    apb(1'b0, `OFS_CTL2, 32'h0);
    chk("control two bits", 32'h0000_E73F, rd);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped refusal", 1, err);
    for (int v = 0; v < 8; v++) begin
      apb(1'b1, `OFS_CTL2, v << 13);
      @(posedge clk_i);
      chk("positive ref", (v == 1 || v == 3), ref_pos_ext_o);
      chk("negative ref", (v == 2 || v == 3), ref_neg_ext_o);
    end
    // software-ended conversions in every format and both resolutions
    apb(1'b1, `OFS_CTL3, 32'h0000_0003);
    for (int i = 0; i < 8; i++) begin
      c1 = 16'(i << 8);
      level <= i[2] ? 12'h5A3 : 12'h2A5;
      apb(1'b1, `OFS_CTL1, c1 | 16'h8000);
      apb(1'b1, `OFS_CTL1, c1 | 16'h8002);
      apb(1'b1, `OFS_CTL1, c1 | 16'h8000);
      watch(1'b0, 400);
      chk("formatted result", fmt_exp(i[2], i[1:0], level), result_o);
      chk("conversion time", 1, k >= (i[2] ? 48 : 40) && k < 70);
      apb(1'b0, `OFS_CTL1, 32'h0);
      chk("done set", 1, rd[0]);
      apb(1'b1, `OFS_CTL1, c1);
      apb(1'b0, `OFS_CTL1, 32'h0);
      chk("done cleared", 0, rd[0]);
    end
    // hardware trigger sources; code 4 is reserved and must not end sampling
    level <= 12'h100;
    for (int t = 1; t < 5; t++) begin
      apb(1'b1, `OFS_CTL1, 16'h8000 | 16'(t << 5));
      apb(1'b1, `OFS_CTL1, 16'h8002 | 16'(t << 5));
      repeat (3) @(posedge clk_i);
      ext_trig_pin_i <= (t == 1);
      timer_compare_i <= (t == 2);
      pwm_interval_i <= (t == 3);
      @(posedge clk_i);
      timer_compare_i <= 1'b0;
      pwm_interval_i <= 1'b0;
      watch(1'b0, 400);
      ext_trig_pin_i <= 1'b0;
      chk("trigger result", t < 4, result_valid_o);
      apb(1'b0, `OFS_CTL1, 32'h0);
      chk("sampling bit", t == 4, rd[1]);
      apb(1'b1, `OFS_CTL1, 32'h0);
    end
    // internal counter ends sampling after four ticks of four cycles
    apb(1'b1, `OFS_CTL3, 32'h0000_0403);
    apb(1'b1, `OFS_CTL1, 32'h0000_80E0);
    apb(1'b1, `OFS_CTL1, 32'h0000_80E2);
    watch(1'b0, 400);
    chk("sample length", 1, ns >= 13 && ns <= 24);
    // auto restart, three sequences per group, split buffer, ordered dma
    apb(1'b1, `OFS_CTL2, 32'h0000_000A);
    apb(1'b1, `OFS_CTL1, 32'h0000_90E4);
    watch(1'b1, 2000);
    chk("results per group", 3, nv);
    chk("dma request", 1, dma_req_o);
    watch(1'b0, 400);
    chk("upper half start", 12'h008, result_addr_o);
    apb(1'b0, `OFS_CTL2, 32'h0);
    chk("half status", 32'h0000_008A, rd);
    // two channels in sequence, scatter/gather addresses from the input index
    apb(1'b1, `OFS_CTL1, 32'h0000_0000);
    apb(1'b1, `OFS_CTL2, 32'h0000_0100);
    apb(1'b1, `OFS_INSEL, 32'h0000_0005);
    apb(1'b1, `OFS_CTL1, 32'h0000_80E0);
    apb(1'b1, `OFS_CTL1, 32'h0000_80E2);
    watch(1'b0, 400);
    chk("scatter address ch0", 12'h005, result_addr_o);
    watch(1'b1, 400);
    chk("channels converted", 1, nv);
    chk("scatter address ch1", 12'h000, result_addr_o);
    // idle handling
    apb(1'b1, `OFS_CTL1, 32'h0000_A000);
    idle_mode_i <= 1'b1;
    @(posedge clk_i);
    chk("idle stop", 0, converter_enable_o);
    apb(1'b1, `OFS_CTL1, 32'h0000_8000);
    @(posedge clk_i);
    chk("idle continue", 1, converter_enable_o);
    wrap_up;
  end
endmodule // sar_adc_control_sequencer_tb_top
bind sar_adc_control_sequencer sar_adc_props props (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .prdata_o, .pslverr_o, .idle_mode_i, .converter_enable_o, .sample_o,
  .ref_pos_ext_o, .ref_neg_ext_o, .result_o, .result_valid_o, .group_done_o, .dma_req_o);
`default_nettype wire
